/* File: rtl/comparator_control.sv */
// digital control around the analog comparator: registers, input steering,
// polarity, timer-clock sampling, pin route, readback and event pulse
// assumes the raw comparator level and the timer clock level are synchronous
// to ref_clk; the analog core decodes the registered select outputs
`timescale 1ns/1ps
module comparator_control #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic                                   ref_clk,
  input  wire logic                                   reset_n,
  // register port
  input  wire logic [comparator_control_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0]                      reg_wdata,
  input  wire logic                                   reg_write,
  input  wire logic                                   reg_read,
  output logic      [DATA_W-1:0]                      reg_rdata,
  // analog core
  input  wire logic                                   comp_raw,
  input  wire logic                                   timer_two_prescaled_clock,
  output comparator_control_pkg::analog_sel_t         analog_sel,
  output comparator_control_pkg::ladder_fraction_t    ladder_fraction,
  // pin and event
  output logic                                        comparator_output_pin_out,
  output logic                                        comparator_output_pin_oe,
  output logic                                        comp_event
);

  if (DATA_W != comparator_control_pkg::DATA_W) begin : g_width_check
    $error("comparator_control supports only 8-bit registers");
  end

  logic [7:0] control;
  logic [7:0] refsel;
  logic       timer_prev;
  logic       timer_edge;
  logic       polarity_result;
  logic       sampled_result;
  logic       effective;
  logic       effective_prev;
  logic [5:0] next_minus_select;
  comparator_control_pkg::ladder_fraction_t next_fraction;

  // register writes; the result bit is not storable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= comparator_control_pkg::CONTROL_RESET;
      refsel  <= comparator_control_pkg::REFSEL_RESET;
    end else if (reg_write) begin
      if (reg_addr == comparator_control_pkg::CONTROL_ADDR) begin
        control <= reg_wdata & ~(8'h01 << comparator_control_pkg::CTRL_RESULT_BIT);
      end
      if (reg_addr == comparator_control_pkg::REFSEL_ADDR) begin
        refsel <= reg_wdata & comparator_control_pkg::REF_WRITE_MASK;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        comparator_control_pkg::CONTROL_ADDR: begin
          reg_rdata <= control | ({7'h00, effective} << comparator_control_pkg::CTRL_RESULT_BIT);
        end
        comparator_control_pkg::REFSEL_ADDR: begin
          reg_rdata <= refsel;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // minus input decode
  always_comb begin
    next_minus_select = 6'h00;
    case (control[comparator_control_pkg::CTRL_MINUS_HI:comparator_control_pkg::CTRL_MINUS_LO])
      comparator_control_pkg::MINUS_PIN_A:   next_minus_select[comparator_control_pkg::MSEL_PIN_A] = 1'b1;
      comparator_control_pkg::MINUS_PIN_B:   next_minus_select[comparator_control_pkg::MSEL_PIN_B] = 1'b1;
      comparator_control_pkg::MINUS_BANDGAP: next_minus_select[comparator_control_pkg::MSEL_BANDGAP] = 1'b1;
      comparator_control_pkg::MINUS_PIN_C:   next_minus_select[comparator_control_pkg::MSEL_PIN_C] = 1'b1;
      comparator_control_pkg::MINUS_PIN_D:   next_minus_select[comparator_control_pkg::MSEL_PIN_D] = 1'b1;
      default:                               next_minus_select[comparator_control_pkg::MSEL_LADDER] = 1'b1;
    endcase
  end

  // ladder level as a fraction of supply
  always_comb begin
    next_fraction.numerator   = {1'b0, refsel[comparator_control_pkg::REF_TAP_HI:0]};
    next_fraction.denominator = comparator_control_pkg::DENOM_32;
    case (refsel[comparator_control_pkg::REF_RANGE_HI:comparator_control_pkg::REF_RANGE_LO])
      comparator_control_pkg::RANGE_QUARTER: begin
        next_fraction.numerator   = next_fraction.numerator + comparator_control_pkg::TAP_OFFSET_HIGH;
        next_fraction.denominator = comparator_control_pkg::DENOM_32;
      end
      comparator_control_pkg::RANGE_LOW24: begin
        next_fraction.numerator   = next_fraction.numerator + comparator_control_pkg::TAP_OFFSET_LOW;
        next_fraction.denominator = comparator_control_pkg::DENOM_24;
      end
      comparator_control_pkg::RANGE_FIFTH: begin
        next_fraction.numerator   = next_fraction.numerator + comparator_control_pkg::TAP_OFFSET_HIGH;
        next_fraction.denominator = comparator_control_pkg::DENOM_40;
      end
      default: begin
        next_fraction.numerator   = next_fraction.numerator + comparator_control_pkg::TAP_OFFSET_LOW;
        next_fraction.denominator = comparator_control_pkg::DENOM_32;
      end
    endcase
  end

  // analog steering outputs, registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_sel      <= '0;
      ladder_fraction <= '0;
    end else begin
      analog_sel.comp_enable     <= control[comparator_control_pkg::CTRL_ENABLE_BIT];
      analog_sel.minus_select    <= next_minus_select;
      analog_sel.plus_from_pin_b <= control[comparator_control_pkg::CTRL_PLUS_BIT];
      analog_sel.ladder_range    <= refsel[comparator_control_pkg::REF_RANGE_HI:comparator_control_pkg::REF_RANGE_LO];
      analog_sel.ladder_tap      <= refsel[comparator_control_pkg::REF_TAP_HI:comparator_control_pkg::REF_TAP_LO];
      ladder_fraction            <= next_fraction;
    end
  end

  // polarity applied first so every consumer sees the same sense
  assign polarity_result = control[comparator_control_pkg::CTRL_ENABLE_BIT]
                           & (comp_raw ^ control[comparator_control_pkg::CTRL_INVERT_BIT]);
  assign timer_edge = timer_two_prescaled_clock & ~timer_prev;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_prev <= 1'b0;
    end else begin
      timer_prev <= timer_two_prescaled_clock;
    end
  end

  // sampled copy, held between timer clock edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampled_result <= 1'b0;
    end else if (timer_edge) begin
      sampled_result <= polarity_result;
    end
  end

  assign effective = control[comparator_control_pkg::CTRL_SAMPLE_BIT] ? sampled_result
                                                                       : polarity_result;

  // pin route overrides the pin direction
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      comparator_output_pin_out <= 1'b0;
      comparator_output_pin_oe  <= 1'b0;
    end else begin
      comparator_output_pin_oe  <= refsel[comparator_control_pkg::REF_ROUTE_BIT];
      comparator_output_pin_out <= refsel[comparator_control_pkg::REF_ROUTE_BIT] & effective;
    end
  end

  // one-cycle event on a rising result
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      effective_prev <= 1'b0;
      comp_event     <= 1'b0;
    end else begin
      effective_prev <= effective;
      comp_event     <= effective & ~effective_prev;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_minus_decode: assert property (
    analog_sel.minus_select[comparator_control_pkg::MSEL_BANDGAP]
      == ($past(control[3:1]) == comparator_control_pkg::MINUS_BANDGAP))
    else $error("minus select does not follow control field");

  chk_plus_select: assert property (
    ##1 analog_sel.plus_from_pin_b == $past(control[comparator_control_pkg::CTRL_PLUS_BIT]))
    else $error("plus select does not follow control bit");

  chk_case_one_cfg: assert property (
    control == 8'h80 |=> analog_sel.comp_enable
      && analog_sel.minus_select == 6'h01 && !analog_sel.plus_from_pin_b)
    else $error("control 0x80 not applied");

  chk_case_two_cfg: assert property (
    control == 8'h97 && reg_write == 1'b0 |=> analog_sel.comp_enable
      && analog_sel.minus_select == 6'h08 && analog_sel.plus_from_pin_b
      && (polarity_result == (comp_raw ^ 1'b1)))
    else $error("control 0x97 not applied");

  chk_pin_route: assert property (
    refsel[7] |=> comparator_control_output_check(comparator_output_pin_oe,
                                                  comparator_output_pin_out, $past(effective)))
    else $error("routed pin does not carry result");

  chk_sample_hold: assert property (
    control[5] && !timer_edge && !reg_write && $stable(control)
      |=> $stable(sampled_result) && effective == sampled_result)
    else $error("sampled result changed between timer edges");

  chk_direct_invert: assert property (
    control[7] && !control[5] && refsel[7]
      |=> comparator_output_pin_out == $past(comp_raw ^ control[4]))
    else $error("direct result polarity wrong");

  chk_event_pulse: assert property (
    comp_event |-> $past(effective) && !$past(effective_prev) ##1 !comp_event)
    else $error("event pulse not tied to rising result");

  chk_tap_eighteen: assert property (
    refsel[5:0] == 6'h09 |=> ladder_fraction.numerator == 5'h12 && ladder_fraction.denominator == 6'h20)
    else $error("range 00 tap 9 not 18/32");

  chk_tap_twentytwo: assert property (
    refsel[5:0] == 6'h2d |=> ladder_fraction.numerator == 5'h16 && ladder_fraction.denominator == 6'h28)
    else $error("range 10 tap 13 not 22/40");

  // register and steering checks
  chk_enable_follow: assert property (
    ##1 analog_sel.comp_enable == $past(control[comparator_control_pkg::CTRL_ENABLE_BIT]))
    else $error("enable does not follow control bit");

  chk_minus_ladder: assert property (
    control[3:2] == 2'h3 |=> analog_sel.minus_select == 6'h08)
    else $error("codes 110 and 111 do not select the ladder");

  chk_range_tap: assert property (
    ##1 {analog_sel.ladder_range, analog_sel.ladder_tap} == $past(refsel[5:0]))
    else $error("ladder range or tap does not follow reference register");

  chk_range_low24: assert property (
    refsel[5:0] == 6'h1f
      |=> ladder_fraction.numerator == 5'h10 && ladder_fraction.denominator == 6'h18)
    else $error("range 01 tap 15 not 16/24");

  chk_range_top: assert property (
    refsel[5:0] == 6'h3f
      |=> ladder_fraction.numerator == 5'h10 && ladder_fraction.denominator == 6'h20)
    else $error("range 11 tap 15 not 16/32");

  chk_refsel_bit6: assert property (
    !refsel[6])
    else $error("reference bit 6 stored a one");

  chk_result_clear: assert property (
    !control[comparator_control_pkg::CTRL_RESULT_BIT])
    else $error("result bit stored by a write");

  chk_readback_result: assert property (
    reg_read && reg_addr == comparator_control_pkg::CONTROL_ADDR
      |=> reg_rdata[comparator_control_pkg::CTRL_RESULT_BIT] == $past(effective))
    else $error("readback result bit does not show the result");

  chk_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");

  // result path checks
  chk_route_off: assert property (
    !refsel[comparator_control_pkg::REF_ROUTE_BIT]
      |=> !comparator_output_pin_oe && !comparator_output_pin_out)
    else $error("pin driven while route is off");

  chk_sample_capture: assert property (
    timer_edge |=> sampled_result == $past(polarity_result))
    else $error("timer edge did not capture the result");

  chk_sample_invert: assert property (
    timer_edge && control[7] |=> sampled_result == ($past(comp_raw) ^ $past(control[4])))
    else $error("sampled result not inverted before capture");

  chk_event_rise: assert property (
    effective && !effective_prev |=> comp_event)
    else $error("rising result gave no event");

  cov_sampled_event: cover property (control[5] && timer_edge ##1 comp_event);
  cov_routed_high: cover property (comparator_output_pin_oe && comparator_output_pin_out);
  cov_bandgap_ladder: cover property (control[3:0] == 4'h4 && control[7]);
  cov_routed_event: cover property (comparator_output_pin_oe && comp_event);
  cov_fifth_range: cover property (analog_sel.ladder_range == 2'h2 && analog_sel.comp_enable);

  function automatic logic comparator_control_output_check(input logic oe, input logic out,
                                                           input logic level);
    return oe && (out == level);
  endfunction : comparator_control_output_check

endmodule : comparator_control

/* File: rtl/comparator_control_pkg.sv */
// constants, field layout and carrier types for the comparator control logic
// assumes an 8-bit register port with two registers at word indices 0 and 1
package comparator_control_pkg;

  // register map
  localparam logic [3:0] CONTROL_ADDR   = 4'h0;
  localparam logic [3:0] REFSEL_ADDR    = 4'h1;
  localparam int         ADDR_W         = 4;
  localparam int         DATA_W         = 8;

  // control register fields
  localparam int CTRL_ENABLE_BIT  = 7;
  localparam int CTRL_RESULT_BIT  = 6;
  localparam int CTRL_SAMPLE_BIT  = 5;
  localparam int CTRL_INVERT_BIT  = 4;
  localparam int CTRL_MINUS_HI    = 3;
  localparam int CTRL_MINUS_LO    = 1;
  localparam int CTRL_PLUS_BIT    = 0;

  // reference select register fields
  localparam int REF_ROUTE_BIT    = 7;
  localparam int REF_RANGE_HI     = 5;
  localparam int REF_RANGE_LO     = 4;
  localparam int REF_TAP_HI       = 3;
  localparam int REF_TAP_LO       = 0;
  localparam logic [7:0] REF_WRITE_MASK = 8'hbf;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] REFSEL_RESET  = 8'h00;

  // minus input codes
  localparam logic [2:0] MINUS_PIN_A   = 3'h0;
  localparam logic [2:0] MINUS_PIN_B   = 3'h1;
  localparam logic [2:0] MINUS_BANDGAP = 3'h2;
  localparam logic [2:0] MINUS_LADDER  = 3'h3;
  localparam logic [2:0] MINUS_PIN_C   = 3'h4;
  localparam logic [2:0] MINUS_PIN_D   = 3'h5;

  // one-hot minus select positions
  localparam int MSEL_PIN_A = 0;
  localparam int MSEL_PIN_B = 1;
  localparam int MSEL_BANDGAP = 2;
  localparam int MSEL_LADDER = 3;
  localparam int MSEL_PIN_C = 4;
  localparam int MSEL_PIN_D = 5;

  // ladder range codes, offsets added to the tap and full-scale denominators
  localparam logic [1:0] RANGE_QUARTER = 2'h0;
  localparam logic [1:0] RANGE_LOW24   = 2'h1;
  localparam logic [1:0] RANGE_FIFTH   = 2'h2;
  localparam logic [1:0] RANGE_LOW32   = 2'h3;
  localparam logic [4:0] TAP_OFFSET_HIGH = 5'h09;
  localparam logic [4:0] TAP_OFFSET_LOW  = 5'h01;
  localparam logic [5:0] DENOM_32 = 6'h20;
  localparam logic [5:0] DENOM_24 = 6'h18;
  localparam logic [5:0] DENOM_40 = 6'h28;

  typedef struct packed {
    logic       comp_enable;
    logic [5:0] minus_select;
    logic       plus_from_pin_b;
    logic [1:0] ladder_range;
    logic [3:0] ladder_tap;
  } analog_sel_t;

  typedef struct packed {
    logic [4:0] numerator;
    logic [5:0] denominator;
  } ladder_fraction_t;

endpackage : comparator_control_pkg

/* File: tb/analog_core_model.sv */
// behavioural analog side: input steering, ladder, comparator and timer clock
// assumes pin and supply levels in millivolts driven by the bench
`timescale 1ns/1ps
module analog_core_model (
  // clock
  input wire logic                                  ref_clk,
  // selects from the control logic
  input wire comparator_control_pkg::analog_sel_t      analog_sel,
  input wire comparator_control_pkg::ladder_fraction_t ladder_fraction,
  // levels and timer run from the bench
  input wire logic [15:0]                           vdd_mv,
  input wire logic [3:0][15:0]                      pin_mv,
  input wire logic                                  tmr_run,
  // towards the control logic
  output logic                                      comp_raw,
  output logic                                      timer_two_prescaled_clock
);
  logic [15:0] ladder_mv;
  logic [15:0] minus_mv;
  logic [15:0] plus_mv;
  logic [1:0]  div = 2'h0;

  initial comp_raw = 1'b0;

  always_comb begin
    ladder_mv = (ladder_fraction.denominator == 6'h00) ? 16'h0000 :
      16'((32'(vdd_mv) * 32'(ladder_fraction.numerator)) /
          32'(ladder_fraction.denominator));
    minus_mv = ladder_mv;
    if (analog_sel.minus_select[0]) minus_mv = pin_mv[0];
    if (analog_sel.minus_select[1]) minus_mv = pin_mv[1];
    if (analog_sel.minus_select[2]) minus_mv = 16'h04b0;
    if (analog_sel.minus_select[4]) minus_mv = pin_mv[2];
    if (analog_sel.minus_select[5]) minus_mv = pin_mv[3];
    plus_mv = analog_sel.plus_from_pin_b ? pin_mv[1] : ladder_mv;
  end

  // a disabled core gives no steady level
  always @(posedge ref_clk) begin
    comp_raw <= analog_sel.comp_enable ? (plus_mv > minus_mv) : ~comp_raw;
  end

  // timer clock stands still while not running
  always @(posedge ref_clk) begin
    if (tmr_run) div <= div + 2'h1;
  end
  assign timer_two_prescaled_clock = div[1];
endmodule : analog_core_model

/* File: tb/testbench.sv */
// self-checking bench for the comparator control logic
// assumes the analog side model in analog_core_model
`timescale 1ns/1ps
module testbench;
  logic ref_clk, reset_n, reg_write, reg_read, comp_raw, tclk;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  comparator_control_pkg::analog_sel_t      asel;
  comparator_control_pkg::ladder_fraction_t lf;
  logic pin_out, pin_oe, comp_event, tmr_run;
  logic [15:0] vdd_mv;
  logic [3:0][15:0] pin_mv;
  int num_errors = 0;
  int tests_run = 0;
  int events = 0;

  comparator_control u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .comp_raw(comp_raw), .timer_two_prescaled_clock(tclk),
    .analog_sel(asel), .ladder_fraction(lf), .comparator_output_pin_out(pin_out),
    .comparator_output_pin_oe(pin_oe), .comp_event(comp_event));
  analog_core_model u_core (.ref_clk(ref_clk), .analog_sel(asel), .ladder_fraction(lf),
    .vdd_mv(vdd_mv), .pin_mv(pin_mv), .tmr_run(tmr_run), .comp_raw(comp_raw),
    .timer_two_prescaled_clock(tclk));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (comp_event === 1'b1) events++;

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge ref_clk) reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge ref_clk) reg_read <= 1'b0;
    #1 rd = reg_rdata;
    check(what, 16'(exp), 16'(rd));
    @(posedge ref_clk);
  endtask : rdc

  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask : settle

  task automatic t_reset();
    rdc("control reset", 4'h0, 8'h00);
    rdc("refsel reset", 4'h1, 8'h00);
    wr(4'h2, 8'hff);
    rdc("unmapped read", 4'h2, 8'h00);
    rdc("control after unmapped write", 4'h0, 8'h00);
    wr(4'h0, 8'h40);
    rdc("result bit not writable", 4'h0, 8'h00);
  endtask : t_reset

  task automatic t_case_one();
    pin_mv[0] <= 16'h03e8;
    wr(4'h1, 8'h09);
    wr(4'h0, 8'h80);
    settle();
    check("sel direct", 16'({1'b1, 6'h01, 1'b0, 2'h0, 4'h9}), 16'(asel));
    check("fraction 18/32", 16'({5'h12, 6'h20}), 16'(lf));
    check("pin released", 16'h0000, 16'(pin_oe));
    rdc("result high", 4'h0, 8'hc0);
    pin_mv[0] <= 16'h0bb8;
    settle();
    rdc("result low", 4'h0, 8'h80);
  endtask : t_case_one

  task automatic t_case_two();
    pin_mv[1] <= 16'h0bb8;
    wr(4'h1, 8'hed);
    rdc("refsel bit 6 stores 0", 4'h1, 8'had);
    wr(4'h0, 8'h97);
    settle();
    check("sel inverted", 16'({1'b1, 6'h08, 1'b1, 2'h2, 4'hd}), 16'(asel));
    check("fraction 22/40", 16'({5'h16, 6'h28}), 16'(lf));
    check("pin oe", 16'h0001, 16'(pin_oe));
    check("pin low when inverted", 16'h0000, 16'(pin_out));
    rdc("readback inverted low", 4'h0, 8'h97);
    events = 0;
    pin_mv[1] <= 16'h01f4;
    settle();
    check("pin high when inverted", 16'h0001, 16'(pin_out));
    check("one event", 16'h0001, 16'(events));
    rdc("readback inverted high", 4'h0, 8'hd7);
    wr(4'h1, 8'h2d);
    settle();
    check("route off", 16'h0000, 16'(pin_oe));
  endtask : t_case_two

  task automatic t_minus();
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, 8'(8'h80 | (c << 1)));
      settle();
      check("minus select", (c < 6) ? 16'(1 << c) : 16'h0008, 16'(asel.minus_select));
    end
  endtask : t_minus

  task automatic t_ranges();
    logic [3:0] tap;
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 2; k++) begin
        tap = k ? 4'hf : 4'h0;
        wr(4'h1, {2'h0, 2'(r), tap});
        settle();
        check("range tap", 16'({2'(r), tap}), 16'({asel.ladder_range, asel.ladder_tap}));
        check("numerator", 16'((r[0] ? 1 : 9) + tap), 16'(lf.numerator));
        check("denominator", (r == 1) ? 16'h0018 : (r == 2) ? 16'h0028 : 16'h0020,
              16'(lf.denominator));
      end
    end
  endtask : t_ranges

  task automatic t_supply();
    wr(4'h0, 8'h84);
    for (int t = 0; t < 16; t++) begin
      wr(4'h1, 8'(t));
      settle();
      rdc("bandgap versus ladder", 4'h0, ((t + 9) * 3300 / 32 > 1200) ? 8'hc4 : 8'h84);
    end
  endtask : t_supply

  task automatic t_sampled();
    pin_mv[0] <= 16'h03e8;
    wr(4'h1, 8'h09);
    wr(4'h0, 8'ha0);
    tmr_run <= 1'b1;
    repeat (16) @(posedge ref_clk);
    tmr_run <= 1'b0;
    settle();
    rdc("sampled high", 4'h0, 8'he0);
    pin_mv[0] <= 16'h0bb8;
    settle();
    rdc("sampled held", 4'h0, 8'he0);
    tmr_run <= 1'b1;
    repeat (16) @(posedge ref_clk);
    tmr_run <= 1'b0;
    settle();
    rdc("sampled updated", 4'h0, 8'ha0);
  endtask : t_sampled

  initial begin
    for (int i = 0; i < 20000; i++) @(posedge ref_clk);
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    complete_run();
  end

  initial begin
    reset_n = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; reg_write = 1'b0;
    reg_read = 1'b0; tmr_run = 1'b0; vdd_mv = 16'h0ce4;
    // pins a,b,c,d in millivolts; digital input buffers assumed off
    pin_mv = {16'h0bb8, 16'h0bb8, 16'h0bb8, 16'h0bb8};
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_case_one();
    t_case_two();
    t_minus();
    t_ranges();
    t_supply();
    t_sampled();
    complete_run();
  end
endmodule : testbench
